/* core/dsc_defs.svh */
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// program counter and fetch
`define DSC_RESET_VEC 23'h000000
`define DSC_PC_STEP 23'h000002

// instruction word field ranges
`define DSC_F_OP 23:16
`define DSC_F_WS 3:0
`define DSC_F_SMODE 6:4
`define DSC_F_WD 10:7
`define DSC_F_DMODE 13:11
`define DSC_F_BYTE 14
`define DSC_F_WB 18:15
`define DSC_F_FILE 12:0
`define DSC_F_FDEST 13
`define DSC_F_BIT4 15:12
`define DSC_F_BITIND 14
`define DSC_F_TEN_BIT_LITERAL 13:4
`define DSC_F_LITSEP 19
`define DSC_F_ACC 18
`define DSC_F_AWB 17:16
`define DSC_F_PAIR 15:13
`define DSC_F_WX 12:9
`define DSC_F_WY 8:5
`define DSC_F_WXD 4:3
`define DSC_F_WYD 2:1
`define DSC_F_SHREG 17
`define DSC_F_SHWN 16:13
`define DSC_F_SHLIT 12:7
`define DSC_F_PLO 15:0
`define DSC_F_PHI 6:0

// opcode values and class masks
`define DSC_OP_NOP 8'h00
`define DSC_OP_IJMP 8'h01
`define DSC_OP_CALL 8'h02
`define DSC_OP_GOTO 8'h04
`define DSC_OP_IRET 8'h05
`define DSC_OP_RET 8'h06
`define DSC_OP_LOOP 8'h08
`define DSC_OP_UJMP 8'h37
`define DSC_MSK_WIDE 8'hE0
`define DSC_MSK_NARROW 8'hF8
`define DSC_VAL_CBR 8'h30
`define DSC_VAL_DEFAULT_WORK_REG 8'h40
`define DSC_VAL_LIT 8'h60
`define DSC_VAL_FILE 8'h80
`define DSC_VAL_BIT 8'hA8
`define DSC_VAL_TBL 8'hB8
`define DSC_VAL_MAC 8'hC0
`define DSC_VAL_DSP 8'hC8
`define DSC_VAL_DIV 8'hD8
`define DSC_VAL_SKIP 8'hE0
`define DSC_VAL_MOVD 8'hE8

// cycle counts
`define DSC_CYC_ONE 2'h1
`define DSC_CYC_TWO 2'h2
`define DSC_CYC_THREE 2'h3

// operand limits and fixed registers
`define DSC_PAIR_MAX 3'h5
`define DSC_AWB_REG 4'hD
`define DSC_AWB_POSTINC 2'h2
`define DSC_PREFETCH_BASE 2'h1
`define DSC_DBG_RAM_BYTES 13'h0050
`define DSC_DBG_PAIRS 3

`endif

/* core/dsc_pkg.sv */
package dsc_pkg;

  typedef enum logic [4:0] {
    DSC_CL_NOP = 5'h00,
    DSC_CL_DEFAULT_WORK_REG = 5'h01,
    DSC_CL_FILE = 5'h02,
    DSC_CL_BIT = 5'h03,
    DSC_CL_LIT = 5'h04,
    DSC_CL_MAC = 5'h05,
    DSC_CL_DSP = 5'h06,
    DSC_CL_DIV = 5'h07,
    DSC_CL_UJMP = 5'h08,
    DSC_CL_CBR = 5'h09,
    DSC_CL_IJMP = 5'h0A,
    DSC_CL_TBL = 5'h0B,
    DSC_CL_RET = 5'h0C,
    DSC_CL_SKIP = 5'h0D,
    DSC_CL_MOVD = 5'h0E,
    DSC_CL_TWOJ = 5'h0F,
    DSC_CL_TWOL = 5'h10,
    DSC_CL_ILL = 5'h11
  } dsc_class_e;

  typedef enum logic [2:0] {
    DSC_ST_ISSUE = 3'h0,
    DSC_ST_WORD2 = 3'h1,
    DSC_ST_NOPS = 3'h2,
    DSC_ST_SKIP1 = 3'h3,
    DSC_ST_SKIP2 = 3'h4
  } dsc_state_e;

  typedef struct packed {
    dsc_class_e opClass;
    logic [7:0] opcode;
    logic byteMode;
    logic [3:0] baseWorkReg;
    logic [3:0] sourceWorkReg;
    logic [2:0] srcMode;
    logic [3:0] destWorkReg;
    logic [2:0] dstMode;
    logic [12:0] fileAddr;
    logic destIsDefaultWorkReg;
    logic [3:0] bitSel;
    logic bitIndirect;
    logic [9:0] tenBitLiteral;
    logic litDestPresent;
    logic accB;
    logic [3:0] mulRegX;
    logic [3:0] mulRegY;
    logic [3:0] xPrefetch;
    logic [3:0] yPrefetch;
    logic [3:0] xDest;
    logic [3:0] yDest;
    logic accWritebackEn;
    logic [3:0] accWritebackReg;
    logic accWritebackInd;
    logic shiftFromReg;
    logic [5:0] shiftAmount;
    logic [22:0] programAddrLiteral;
  } dsc_dec_s;

  typedef struct packed {
    logic carry;
    logic digitCarry;
    logic negative;
    logic overflow;
    logic zero;
    logic accAOverflow;
    logic accBOverflow;
    logic accAClampFlag;
    logic accBClampFlag;
  } dsc_flags_s;

endpackage

/* core/dsc_op_class.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defs.svh"

module dsc_op_class (
  input wire logic [7:0] opcode,
  output var dsc_pkg::dsc_class_e opClass,
  output logic twoWord,
  output logic [1:0] baseCycles
);
  wire isNarrowCbr = (opcode & `DSC_MSK_NARROW) == `DSC_VAL_CBR;
  wire isWreg = (opcode & `DSC_MSK_WIDE) == `DSC_VAL_DEFAULT_WORK_REG;
  wire isLit = (opcode & `DSC_MSK_WIDE) == `DSC_VAL_LIT;
  wire isFile = (opcode & `DSC_MSK_NARROW) == `DSC_VAL_FILE;
  wire isBit = (opcode & `DSC_MSK_NARROW) == `DSC_VAL_BIT;
  wire isTbl = (opcode & `DSC_MSK_NARROW) == `DSC_VAL_TBL;
  wire isMac = (opcode & `DSC_MSK_NARROW) == `DSC_VAL_MAC;
  wire isDsp = (opcode & `DSC_MSK_NARROW) == `DSC_VAL_DSP;
  wire isDiv = (opcode & `DSC_MSK_NARROW) == `DSC_VAL_DIV;
  wire isSkip = (opcode & `DSC_MSK_NARROW) == `DSC_VAL_SKIP;
  wire isMovd = (opcode & `DSC_MSK_NARROW) == `DSC_VAL_MOVD;
  wire isTwoJ = (opcode == `DSC_OP_CALL) || (opcode == `DSC_OP_GOTO);
  wire isRet = (opcode == `DSC_OP_RET) || (opcode == `DSC_OP_IRET);

  // unconditional jump sits inside the conditional range, so test it first
  assign opClass =
    (opcode == `DSC_OP_NOP) ? dsc_pkg::DSC_CL_NOP :
    isTwoJ ? dsc_pkg::DSC_CL_TWOJ :
    (opcode == `DSC_OP_LOOP) ? dsc_pkg::DSC_CL_TWOL :
    (opcode == `DSC_OP_IJMP) ? dsc_pkg::DSC_CL_IJMP :
    isRet ? dsc_pkg::DSC_CL_RET :
    (opcode == `DSC_OP_UJMP) ? dsc_pkg::DSC_CL_UJMP :
    isNarrowCbr ? dsc_pkg::DSC_CL_CBR :
    isWreg ? dsc_pkg::DSC_CL_DEFAULT_WORK_REG :
    isLit ? dsc_pkg::DSC_CL_LIT :
    isFile ? dsc_pkg::DSC_CL_FILE :
    isBit ? dsc_pkg::DSC_CL_BIT :
    isTbl ? dsc_pkg::DSC_CL_TBL :
    isMac ? dsc_pkg::DSC_CL_MAC :
    isDsp ? dsc_pkg::DSC_CL_DSP :
    isDiv ? dsc_pkg::DSC_CL_DIV :
    isSkip ? dsc_pkg::DSC_CL_SKIP :
    isMovd ? dsc_pkg::DSC_CL_MOVD : dsc_pkg::DSC_CL_ILL;

  // exactly three opcodes take two program words
  assign twoWord = isTwoJ || (opcode == `DSC_OP_LOOP);

  assign baseCycles =
    isRet ? `DSC_CYC_THREE :
    (twoWord || isMovd || isTbl || (opcode == `DSC_OP_IJMP) ||
     (opcode == `DSC_OP_UJMP)) ? `DSC_CYC_TWO :
    `DSC_CYC_ONE;
endmodule

`default_nettype wire

/* core/dsc_instruction_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defs.svh"

module dsc_instruction_decode #(
  parameter int DBG_PAIRS = `DSC_DBG_PAIRS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [23:0] progWord,
  input wire logic progValid,
  input wire logic condTrue,
  input wire logic pcLoad,
  input wire logic [22:0] pcLoadAddr,
  input wire dsc_pkg::dsc_flags_s flagWrite,
  input wire dsc_pkg::dsc_flags_s flagValue,
  input wire logic debugEnable,
  input wire logic [1:0] debugPairSel,
  output logic [22:0] fetchAddr,
  output logic fetchReq,
  output var dsc_pkg::dsc_dec_s dec,
  output logic issueValid,
  output logic nopCycle,
  output logic [1:0] instrCycles,
  output logic illegalOp,
  output logic debugRamViolation,
  output logic [DBG_PAIRS-1:0] debugPinOwned,
  output var dsc_pkg::dsc_flags_s status
);
  dsc_pkg::dsc_state_e state;
  dsc_pkg::dsc_state_e next_state;
  dsc_pkg::dsc_class_e wordClass;
  dsc_pkg::dsc_class_e firstClass;
  dsc_pkg::dsc_class_e curClass;
  dsc_pkg::dsc_dec_s next_dec;
  dsc_pkg::dsc_flags_s next_status;
  logic [23:0] firstWord;
  logic [1:0] nopLeft;
  logic [1:0] next_nopLeft;
  logic [1:0] next_cycles;
  logic [22:0] next_pc;
  logic wordTwo;
  logic [1:0] baseCycles;
  logic next_issue;
  logic next_nop;
  logic [DBG_PAIRS-1:0] next_pins;

  dsc_op_class u_class (
    .opcode(progWord[`DSC_F_OP]),
    .opClass(wordClass),
    .twoWord(wordTwo),
    .baseCycles(baseCycles)
  );

  // a word is taken whenever memory offers one outside no-op cycles
  wire inIssue = state == dsc_pkg::DSC_ST_ISSUE;
  wire inWord2 = state == dsc_pkg::DSC_ST_WORD2;
  wire take = progValid && (state != dsc_pkg::DSC_ST_NOPS);
  wire issueSingle = take && inIssue && !wordTwo;
  wire issueDouble = take && inWord2;
  wire skipTaken = issueSingle && condTrue &&
                   (wordClass == dsc_pkg::DSC_CL_SKIP);

  // operands come from the held first word while the second one arrives
  wire [23:0] w = inWord2 ? firstWord : progWord;
  assign curClass = inWord2 ? firstClass : wordClass;

  wire isByte = w[`DSC_F_BYTE] && (curClass != dsc_pkg::DSC_CL_BIT);
  wire [9:0] litRaw = w[`DSC_F_TEN_BIT_LITERAL];
  wire [2:0] pairIdx = w[`DSC_F_PAIR];
  wire [1:0] awbSel = w[`DSC_F_AWB];
  wire [12:0] fileField = w[`DSC_F_FILE];
  wire isFileOp = curClass == dsc_pkg::DSC_CL_FILE;
  wire isMacOp = curClass == dsc_pkg::DSC_CL_MAC;
  wire isDivOp = curClass == dsc_pkg::DSC_CL_DIV;
  wire isCond = curClass == dsc_pkg::DSC_CL_CBR;

  // six distinct pairs from registers 4..7; index 6 and 7 are refused
  function automatic logic [7:0] mulPair(input logic [2:0] idx);
    case (idx)
      3'h0: mulPair = {4'h4, 4'h5};
      3'h1: mulPair = {4'h4, 4'h6};
      3'h2: mulPair = {4'h4, 4'h7};
      3'h3: mulPair = {4'h5, 4'h6};
      3'h4: mulPair = {4'h5, 4'h7};
      3'h5: mulPair = {4'h6, 4'h7};
      default: mulPair = {4'h0, 4'h0};
    endcase
  endfunction

  wire [7:0] pairRegs = mulPair(pairIdx);
  wire pairBad = isMacOp && (pairIdx > `DSC_PAIR_MAX);
  wire awbBad = isMacOp && (awbSel == 2'h3);
  // divide operands must be plain register contents, no pointer modes
  wire divBad = isDivOp &&
                ((w[`DSC_F_SMODE] != 3'h0) || (w[`DSC_F_DMODE] != 3'h0));
  wire classBad = curClass == dsc_pkg::DSC_CL_ILL;

  always_comb begin
    next_dec = '0;
    next_dec.opClass = curClass;
    next_dec.opcode = w[`DSC_F_OP];
    next_dec.byteMode = isByte;
    next_dec.baseWorkReg = w[`DSC_F_WB];
    next_dec.sourceWorkReg = w[`DSC_F_WS];
    next_dec.srcMode = isDivOp ? 3'h0 : w[`DSC_F_SMODE];
    next_dec.destWorkReg = w[`DSC_F_WD];
    next_dec.dstMode = isDivOp ? 3'h0 : w[`DSC_F_DMODE];
    // thirteen-bit field covers exactly 0..0x1FFF
    next_dec.fileAddr = fileField;
    next_dec.destIsDefaultWorkReg = isFileOp &&
                                    !w[`DSC_F_FDEST];
    next_dec.bitSel = w[`DSC_F_BIT4];
    next_dec.bitIndirect = (curClass == dsc_pkg::DSC_CL_BIT) &&
                           w[`DSC_F_BITIND];
    // byte mode cannot carry more than eight significant bits
    next_dec.tenBitLiteral = isByte ? {2'h0, litRaw[7:0]} :
                             litRaw;
    next_dec.litDestPresent = (curClass == dsc_pkg::DSC_CL_LIT) &&
                              w[`DSC_F_LITSEP];
    next_dec.accB = w[`DSC_F_ACC];
    next_dec.mulRegX = pairRegs[7:4];
    next_dec.mulRegY = pairRegs[3:0];
    next_dec.xPrefetch = w[`DSC_F_WX];
    next_dec.yPrefetch = w[`DSC_F_WY];
    next_dec.xDest = {`DSC_PREFETCH_BASE, w[`DSC_F_WXD]};
    next_dec.yDest = {`DSC_PREFETCH_BASE, w[`DSC_F_WYD]};
    next_dec.accWritebackEn = isMacOp && (awbSel != 2'h0);
    next_dec.accWritebackReg = `DSC_AWB_REG;
    next_dec.accWritebackInd = awbSel == `DSC_AWB_POSTINC;
    next_dec.shiftFromReg = w[`DSC_F_SHREG];
    next_dec.shiftAmount = w[`DSC_F_SHREG] ? {2'h0, w[`DSC_F_SHWN]} :
                           w[`DSC_F_SHLIT];
    // target is never odd, whatever the encoding holds
    next_dec.programAddrLiteral = {progWord[`DSC_F_PHI],
                                   w[15:1], 1'b0};
  end

  // sequencing of words and padding no-op cycles
  always_comb begin
    next_state = state;
    next_nopLeft = nopLeft;
    next_cycles = instrCycles;
    next_issue = 1'b0;
    next_nop = 1'b0;
    case (state)
      dsc_pkg::DSC_ST_ISSUE: begin
        if (take && wordTwo) begin
          next_state = dsc_pkg::DSC_ST_WORD2;
        end else if (take) begin
          next_issue = 1'b1;
          if (skipTaken) begin
            next_state = dsc_pkg::DSC_ST_SKIP1;
            next_cycles = `DSC_CYC_TWO;
          end else if (isCond && condTrue) begin
            next_state = dsc_pkg::DSC_ST_NOPS;
            next_nopLeft = 2'h0;
            next_cycles = `DSC_CYC_TWO;
          end else if (isCond || (baseCycles == `DSC_CYC_ONE)) begin
            next_cycles = `DSC_CYC_ONE;
          end else begin
            next_state = dsc_pkg::DSC_ST_NOPS;
            next_nopLeft = baseCycles - `DSC_CYC_TWO;
            next_cycles = baseCycles;
          end
        end
      end
      dsc_pkg::DSC_ST_WORD2: begin
        if (take) begin
          next_state = dsc_pkg::DSC_ST_ISSUE;
          next_issue = 1'b1;
          next_cycles = `DSC_CYC_TWO;
        end
      end
      dsc_pkg::DSC_ST_NOPS: begin
        next_nop = 1'b1;
        if (nopLeft == 2'h0) begin
          next_state = dsc_pkg::DSC_ST_ISSUE;
        end else begin
          next_nopLeft = nopLeft - 2'h1;
        end
      end
      dsc_pkg::DSC_ST_SKIP1: begin
        if (take) begin
          next_nop = 1'b1;
          // a two-word victim costs one more discarded word
          if (wordTwo) begin
            next_state = dsc_pkg::DSC_ST_SKIP2;
            next_cycles = `DSC_CYC_THREE;
          end else begin
            next_state = dsc_pkg::DSC_ST_ISSUE;
          end
        end
      end
      dsc_pkg::DSC_ST_SKIP2: begin
        if (take) begin
          next_nop = 1'b1;
          next_state = dsc_pkg::DSC_ST_ISSUE;
        end
      end
      default: begin
        next_state = dsc_pkg::DSC_ST_ISSUE;
      end
    endcase
  end

  // explicit load from execution wins over the literal and the increment
  wire loadLiteral = issueDouble && (firstClass == dsc_pkg::DSC_CL_TWOJ);
  assign next_pc = pcLoad ? {pcLoadAddr[22:1], 1'b0} :
                   loadLiteral ? next_dec.programAddrLiteral :
                   take ? fetchAddr + `DSC_PC_STEP : fetchAddr;

  // every flag, zero included, takes flagValue where flagWrite is set and holds otherwise
  assign next_status = (status & ~flagWrite) |
                       (flagValue & flagWrite);

  wire fileInDebug = isFileOp && debugEnable &&
                     (fileField < `DSC_DBG_RAM_BYTES);

  // the debugger picks its pair; only that pair is taken from the application
  genvar gi;
  generate
    for (gi = 0; gi < DBG_PAIRS; gi = gi + 1) begin : g_pin
      assign next_pins[gi] = debugEnable &&
                             (debugPairSel == 2'(gi));
    end
  endgenerate

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= dsc_pkg::DSC_ST_ISSUE;
      firstWord <= 24'h000000;
      firstClass <= dsc_pkg::DSC_CL_NOP;
      fetchAddr <= `DSC_RESET_VEC;
      nopLeft <= 2'h0;
    end else begin
      state <= next_state;
      nopLeft <= next_nopLeft;
      fetchAddr <= next_pc;
      if (take && inIssue && wordTwo) begin
        firstWord <= progWord;
        firstClass <= wordClass;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dec <= '0;
      issueValid <= 1'b0;
      nopCycle <= 1'b0;
      instrCycles <= `DSC_CYC_ONE;
      illegalOp <= 1'b0;
      debugRamViolation <= 1'b0;
    end else begin
      issueValid <= next_issue;
      nopCycle <= next_nop;
      instrCycles <= next_cycles;
      illegalOp <= (issueSingle || issueDouble) &&
                   (classBad || pairBad || awbBad || divBad);
      debugRamViolation <= (issueSingle || issueDouble) &&
                           fileInDebug;
      if (issueSingle || issueDouble) begin
        dec <= next_dec;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status <= '0;
      debugPinOwned <= '0;
      fetchReq <= 1'b0;
    end else begin
      status <= next_status;
      debugPinOwned <= next_pins;
      // words fetched during padding would be thrown away anyway
      fetchReq <= next_state != dsc_pkg::DSC_ST_NOPS;
    end
  end
endmodule

`default_nettype wire

/* dv/dsc_decode_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_decode_sva #(
  parameter int DBG_PAIRS = 3
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic progValid,
  input wire logic pcLoad,
  input wire dsc_pkg::dsc_flags_s flagWrite,
  input wire dsc_pkg::dsc_flags_s flagValue,
  input wire logic debugEnable,
  input wire logic [22:0] fetchAddr,
  input wire logic fetchReq,
  input wire dsc_pkg::dsc_dec_s dec,
  input wire logic issueValid,
  input wire logic nopCycle,
  input wire logic [1:0] instrCycles,
  input wire logic illegalOp,
  input wire logic debugRamViolation,
  input wire logic [DBG_PAIRS-1:0] debugPinOwned,
  input wire dsc_pkg::dsc_flags_s status
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_ill_issue: assert property (illegalOp |-> issueValid)
    else $error("illegal flag without an issue");
  a_issue_word: assert property (issueValid |-> $past(progValid))
    else $error("issue without a word taken");
  a_pc_even: assert property (fetchAddr[0] == 1'b0)
    else $error("odd program address");
  a_fetch_hold: assert property (
    !fetchReq && !pcLoad |=> $stable(fetchAddr))
    else $error("address moved in a padding cycle");
  a_ret_padding: assert property (
    issueValid && instrCycles == 2'h3
    |-> !nopCycle && !fetchReq ##1 nopCycle && !fetchReq
    ##1 nopCycle && fetchReq ##1 !nopCycle)
    else $error("three-cycle op without two padding cycles");
  a_single_bare: assert property (
    issueValid && instrCycles == 2'h1 |=> !nopCycle)
    else $error("one-cycle op padded");
  a_dbg_ram: assert property (
    debugRamViolation |-> issueValid && debugEnable
    && dec.opClass == dsc_pkg::DSC_CL_FILE && dec.fileAddr < 13'h0050)
    else $error("debug ram flag without a low file access");
  a_dbg_off: assert property (!debugEnable |=> debugPinOwned == '0)
    else $error("pins reserved with debug off");
  a_dbg_onehot: assert property ($onehot0(debugPinOwned))
    else $error("more than one pin pair reserved");
  a_awb_reg: assert property (
    issueValid && dec.opClass == dsc_pkg::DSC_CL_MAC
    && dec.accWritebackEn && !illegalOp |-> dec.accWritebackReg == 4'hD)
    else $error("write-back not to register 13");
  a_byte_lit: assert property (
    issueValid && dec.opClass == dsc_pkg::DSC_CL_LIT
    && dec.byteMode |-> dec.tenBitLiteral[9:8] == 2'h0)
    else $error("byte literal above 255");
  a_flag_write: assert property (flagWrite != '0 |=>
    ((status ^ $past(flagValue)) & $past(flagWrite)) == '0)
    else $error("flag write not taken");
  a_flag_hold: assert property (flagWrite == '0 |=> $stable(status))
    else $error("flags moved without a write");
endmodule
`default_nettype wire

/* dv/dsc_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_prog_mem (
  input wire logic [22:0] fetchAddr,
  input wire logic fetchReq,
  output logic [23:0] progWord,
  output logic progValid
);
  logic [23:0] mem [8];
  wire logic [23:0] word = mem[fetchAddr[3:1]];
  // unrequested cycles show the inverse, so a held word never looks fresh
  assign progValid = fetchReq;
  assign progWord = fetchReq ? word : ~word;
endmodule
`default_nettype wire

/* dv/dsc_instruction_decode_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dsc_instruction_decode_test;
  typedef struct packed {
    logic [23:0] word;
    logic cond;
    logic [4:0] cls;
    logic [1:0] cyc;
    logic [1:0] nops;
  } dsc_row_s;
  localparam int NPAIR = 3;
  logic mclk, sys_rst, condTrue, pcLoad, debugEnable, progValid, fetchReq;
  logic issueValid, nopCycle, illegalOp, debugRamViolation, sIll, sVio;
  logic [22:0] pcLoadAddr, fetchAddr, sAddr;
  logic [1:0] debugPairSel, instrCycles, sCyc, lastCyc;
  logic [23:0] progWord;
  logic [NPAIR-1:0] debugPinOwned;
  dsc_pkg::dsc_flags_s flagWrite, flagValue, status;
  dsc_pkg::dsc_dec_s dec, sDec;
  int nops, n_mismatch = 0, checked = 0;
  logic [7:0] twoOp [3] = '{8'h02, 8'h08, 8'h04};
  logic [23:0] illWord [5] = '{24'hC0C000, 24'hC0A000, 24'hC30000,
    24'hD80010, 24'hFF0000};
  logic illExp [5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h1};
  dsc_row_s rows [18] = '{
    '{24'h000000, 1'h0, 5'h00, 2'h1, 2'h0},
    '{24'h400000, 1'h0, 5'h01, 2'h1, 2'h0},
    '{24'h800000, 1'h0, 5'h02, 2'h1, 2'h0},
    '{24'hA80000, 1'h0, 5'h03, 2'h1, 2'h0},
    '{24'h600000, 1'h0, 5'h04, 2'h1, 2'h0},
    '{24'hC00000, 1'h0, 5'h05, 2'h1, 2'h0},
    '{24'hC80000, 1'h0, 5'h06, 2'h1, 2'h0},
    '{24'hD80000, 1'h0, 5'h07, 2'h1, 2'h0},
    '{24'h370000, 1'h0, 5'h08, 2'h2, 2'h1},
    '{24'h300000, 1'h0, 5'h09, 2'h1, 2'h0},
    '{24'h300000, 1'h1, 5'h09, 2'h2, 2'h1},
    '{24'h010000, 1'h0, 5'h0A, 2'h2, 2'h1},
    '{24'hB80000, 1'h0, 5'h0B, 2'h2, 2'h1},
    '{24'h060000, 1'h0, 5'h0C, 2'h3, 2'h2},
    '{24'h050000, 1'h0, 5'h0C, 2'h3, 2'h2},
    '{24'hE00000, 1'h0, 5'h0D, 2'h1, 2'h0},
    '{24'hE00000, 1'h1, 5'h0D, 2'h2, 2'h1},
    '{24'hE80000, 1'h0, 5'h0E, 2'h2, 2'h1}
  };

  dsc_instruction_decode #(.DBG_PAIRS(NPAIR)) dsc_instruction_decode_i (
    .mclk, .sys_rst, .progWord, .progValid, .condTrue, .pcLoad, .pcLoadAddr,
    .flagWrite, .flagValue, .debugEnable, .debugPairSel, .fetchAddr,
    .fetchReq, .dec, .issueValid, .nopCycle, .instrCycles, .illegalOp,
    .debugRamViolation, .debugPinOwned, .status);
  dsc_prog_mem dsc_prog_mem_i (.fetchAddr, .fetchReq, .progWord, .progValid);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // snapshot the issue cycle, then count padding up to the next issue
  task automatic waitIssue();
    int k;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (issueValid !== 1'b1 && k < 10);
    chk("issue", issueValid, 32'h1);
    sDec = dec;
    sCyc = instrCycles;
    sAddr = fetchAddr;
    sIll = illegalOp;
    sVio = debugRamViolation;
    nops = 0;
    for (k = 0; k < 4; k++) begin
      if (k > 0 && issueValid === 1'b1) break;
      if (nopCycle === 1'b1) nops++;
      lastCyc = instrCycles;
      @(negedge mclk);
    end
  endtask

  task automatic go(input logic [23:0] w0, w1, w2, input logic c);
    sys_rst = 1'b1;
    dsc_prog_mem_i.mem[0] = w0;
    dsc_prog_mem_i.mem[1] = w1;
    dsc_prog_mem_i.mem[2] = w2;
    condTrue = c;
    @(negedge mclk);
    sys_rst = 1'b0;
    waitIssue();
  endtask

  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end

  initial begin
    sys_rst = 1'b1;
    {condTrue, pcLoad, debugEnable} = 3'h0;
    pcLoadAddr = 23'h000000;
    debugPairSel = 2'h3;
    flagWrite = 9'h000;
    flagValue = 9'h000;
    for (int i = 0; i < 8; i++) dsc_prog_mem_i.mem[i] = 24'h000000;
    repeat (12) @(negedge mclk);
    chk("rstAddr", fetchAddr, 32'h0);
    chk("rstReq", fetchReq, 32'h0);
    chk("rstCyc", instrCycles, 32'h1);
    chk("rstStatus", status, 32'h0);
    foreach (rows[i]) begin
      go(rows[i].word, 24'h000000, 24'h000000, rows[i].cond);
      chk("class", sDec.opClass, rows[i].cls);
      chk("cycles", sCyc, rows[i].cyc);
      chk("nops", nops, rows[i].nops);
      chk("ill", sIll, 32'h0);
    end
    foreach (twoOp[i]) begin
      go({twoOp[i], 16'h1235}, 24'h000045, 24'h000000, 1'b0);
      chk("twoCyc", sCyc, 32'h2);
      chk("twoIll", sIll, 32'h0);
    end
    chk("gotoAddr", sAddr, 32'h451234);
    go(24'h000045, 24'h000000, 24'h000000, 1'b0);
    chk("loneCls", sDec.opClass, 32'h0);
    chk("loneCyc", sCyc, 32'h1);
    go(24'hE00000, 24'h041235, 24'h000045, 1'b1);
    chk("skipCyc", lastCyc, 32'h3);
    chk("skipNops", nops, 32'h2);
    foreach (illWord[i]) begin
      go(illWord[i], 24'h000000, 24'h000000, 1'b0);
      chk("illegal", sIll, illExp[i]);
    end
    go(24'h803FFF, 24'h000000, 24'h000000, 1'b0);
    chk("fileAddr", sDec.fileAddr, 32'h1FFF);
    chk("fileDest", sDec.destIsDefaultWorkReg, 32'h0);
    go(24'h607FF0, 24'h000000, 24'h000000, 1'b0);
    chk("byteLit", sDec.tenBitLiteral, 32'hFF);
    chk("litSame", sDec.litDestPresent, 32'h0);
    go(24'h683FF0, 24'h000000, 24'h000000, 1'b0);
    chk("wordLit", sDec.tenBitLiteral, 32'h3FF);
    chk("litDest", sDec.litDestPresent, 32'h1);
    go(24'hC60000, 24'h000000, 24'h000000, 1'b0);
    chk("awbReg", sDec.accWritebackReg, 32'hD);
    chk("awbInd", sDec.accWritebackInd, 32'h1);
    chk("accB", sDec.accB, 32'h1);
    chk("mulX", sDec.mulRegX, 32'h4);
    chk("mulY", sDec.mulRegY, 32'h5);
    go(24'h438283, 24'h000000, 24'h000000, 1'b0);
    chk("base", sDec.baseWorkReg, 32'h7);
    chk("src", sDec.sourceWorkReg, 32'h3);
    chk("dst", sDec.destWorkReg, 32'h5);
    go(24'hA8D000, 24'h000000, 24'h000000, 1'b0);
    chk("bitSel", sDec.bitSel, 32'hD);
    chk("bitInd", sDec.bitIndirect, 32'h1);
    go(24'hCA6000, 24'h000000, 24'h000000, 1'b0);
    chk("shReg", sDec.shiftFromReg, 32'h1);
    chk("shAmt", sDec.shiftAmount, 32'h3);
    debugEnable = 1'b1;
    go(24'h80004F, 24'h000000, 24'h000000, 1'b0);
    chk("dbgLow", sVio, 32'h1);
    chk("fileWreg", sDec.destIsDefaultWorkReg, 32'h1);
    go(24'h800050, 24'h000000, 24'h000000, 1'b0);
    chk("dbgEdge", sVio, 32'h0);
    for (int p = 0; p < NPAIR; p++) begin
      debugPairSel = p[1:0];
      repeat (2) @(negedge mclk);
      chk("pins", debugPinOwned, 32'h1 << p);
    end
    debugEnable = 1'b0;
    // reset lands after the first word of a jump was taken
    sys_rst = 1'b1;
    dsc_prog_mem_i.mem[0] = 24'h041235;
    dsc_prog_mem_i.mem[1] = 24'h000045;
    @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b1;
    dsc_prog_mem_i.mem[0] = 24'h400000;
    dsc_prog_mem_i.mem[1] = 24'h000000;
    @(negedge mclk);
    chk("midAddr", fetchAddr, 32'h0);
    sys_rst = 1'b0;
    waitIssue();
    chk("midCls", sDec.opClass, 32'h1);
    pcLoadAddr = 23'h000007;
    pcLoad = 1'b1;
    @(negedge mclk);
    pcLoad = 1'b0;
    chk("pcLoad", fetchAddr, 32'h6);
    flagWrite = 9'h1FF;
    flagValue = 9'h1FF;
    @(negedge mclk);
    chk("flagSet", status, 32'h1FF);
    flagWrite = 9'h010;
    flagValue = 9'h000;
    @(negedge mclk);
    chk("flagZero", status, 32'h1EF);
    summarize();
  end
endmodule

bind dsc_instruction_decode dsc_decode_sva #(.DBG_PAIRS(DBG_PAIRS))
  dsc_decode_sva_i (
  .mclk, .sys_rst, .progValid, .pcLoad, .flagWrite, .flagValue, .debugEnable,
  .fetchAddr, .fetchReq, .dec, .issueValid, .nopCycle, .instrCycles,
  .illegalOp, .debugRamViolation, .debugPinOwned, .status);
`default_nettype wire
